// file: rtl/ssdp_params.svh
// Purpose: constants for the synchronous SRAM data port with sleep and burst strap
// Assumes: included by its bare name from the rtl files
// Notes: offsets are byte addresses on the register bus
`ifndef SSDP_PARAMS_SVH
`define SSDP_PARAMS_SVH

// memory geometry
`define SSDP_ADDR_W 17
`define SSDP_LANES 4

// register bus offsets
`define SSDP_CTRL_OFS 4'h0
`define SSDP_STAT_OFS 4'h4

// control register fields and reset value
`define SSDP_CTRL_FORCE_SLEEP 0
`define SSDP_CTRL_RESET 32'h0000_0000

// status register fields
`define SSDP_STAT_SLEEPING 0
`define SSDP_STAT_INTERLEAVED 1
`define SSDP_STAT_CNT_LO 2
`define SSDP_STAT_DRIVING 4
`define SSDP_STAT_BURST_ON 5

// strap settle time after reset, in cycles
`define SSDP_STRAP_WAIT 2'h3

`endif

// file: rtl/ssdp_pkg.sv
// Purpose: shared types for the synchronous SRAM data port
// Assumes: nothing
// Notes: constants live in ssdp_params.svh
package ssdp_pkg;

  // power state, one-hot
  typedef enum logic [1:0] {
    SSDP_RUN = 2'h1,
    SSDP_SLEEP = 2'h2
  } ssdp_state_t;

  // burst order selected by the strap
  typedef enum logic {
    SSDP_LINEAR = 1'b0,
    SSDP_INTERLEAVED = 1'b1
  } ssdp_order_t;

endpackage

// file: rtl/ssdp_burst_seq.sv
// Purpose: low two address bits of a burst step, linear or interleaved
// Assumes: purely combinational, used inside the data port
// Notes: both orders wrap within four accesses
`timescale 1ns/1ps
`default_nettype none
module ssdp_burst_seq (
  input wire logic [1:0] base_bits, // burst_addr_bit1/0 as loaded
  input wire logic [1:0] step, // access number within the burst
  input wire ssdp_pkg::ssdp_order_t order, // linear or interleaved
  output logic [1:0] addr_bits // bits to use for this access
);
  import ssdp_pkg::*;

  // two-bit add wraps by itself; xor is the interleaved sequence
  wire logic [1:0] linear_bits = 2'(base_bits + step);
  wire logic [1:0] inter_bits = base_bits ^ step;
  assign addr_bits = (order == SSDP_INTERLEAVED) ? inter_bits : linear_bits;
endmodule // ssdp_burst_seq
`default_nettype wire

// file: rtl/ssdp_data_port.sv
// Purpose: data port, sleep and burst order logic of a pipelined burst SRAM
// Assumes: controller runs on sys_clk; output_en_n and sleep_request are asynchronous pins
// Notes: pad pull-down on sleep_request and pull-up on the strap sit outside this module
//
// What this block does
// - sleep high stops accesses, memory kept intact
// - sleep held low or floating means normal
// - input data captured on rising clock edge
// - read output is data at sampled address
// - output enable low allows drive, high floats
// - float during write data, deselect, emerging cycle
// - parity bits follow data, gated by lane select
// - strap low linear, high or floating interleaved
// - burst counter steps two low bits, wraps
// - read data driven on next clock rise
// - write data latched on second rise after start
// - output enable acts asynchronously, never clocked
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssdp_params.svh"
module ssdp_data_port #(
  parameter int ADDR_W = `SSDP_ADDR_W, // word address width
  parameter int LANES = `SSDP_LANES // byte lanes, one parity line each
) (
  input wire logic sys_clk, // 40 MHz clock
  input wire logic reset, // synchronous, active high
  input wire logic [ADDR_W-1:0] mem_addr, // word address, low two bits feed the burst
  input wire logic chip_select_n, // combined chip select, active low
  input wire logic write_en_n, // write enable, active low
  input wire logic adv_load_n, // low loads an address, high advances the burst
  input wire logic [LANES-1:0] byte_lane_write_select_n, // per lane write select, active low
  input wire logic output_en_n, // asynchronous output enable, active low
  input wire logic sleep_request, // asynchronous sleep input, active high
  input wire logic burst_order_strap, // low linear, high interleaved
  input wire logic [8*LANES-1:0] data_in, // data pins, input side
  output logic [8*LANES-1:0] data_out, // data pins, output side
  output logic data_oe, // data pins driven when high
  input wire logic [LANES-1:0] parity_lines_in, // parity pins, input side
  output logic [LANES-1:0] parity_lines_out, // parity pins, output side
  output logic parity_lines_oe, // parity pins driven when high
  input wire logic [3:0] avs_address, // register byte address
  input wire logic avs_read, // register read request
  input wire logic avs_write, // register write request
  input wire logic [31:0] avs_writedata, // register write data
  output logic [31:0] avs_readdata, // register read data
  output logic avs_waitrequest // stall until the access is taken
);
  import ssdp_pkg::*;

  localparam int WORD_W = 9 * LANES;
  localparam int DEPTH = 1 << ADDR_W;

  logic [WORD_W-1:0] mem [0:DEPTH-1];
  ssdp_state_t state_reg, state_next;
  ssdp_order_t order_reg;
  logic sleep_meta_reg, sleep_sync_reg, strap_meta_reg, strap_sync_reg;
  logic [1:0] strap_wait_reg;
  logic force_sleep_reg, bus_ack_reg;
  logic [31:0] readdata_reg;
  logic burst_on_reg, burst_wr_reg;
  logic [1:0] burst_cnt_reg;
  logic [ADDR_W-1:0] burst_base_reg;
  logic op1_valid_reg, op1_wr_reg, op2_valid_reg, op2_wr_reg;
  logic [ADDR_W-1:0] op1_addr_reg, op2_addr_reg;
  logic [LANES-1:0] op1_bw_n_reg, op2_bw_n_reg;
  logic drive_reg;
  logic [WORD_W-1:0] rdata_reg;

  // sleep and strap pins pass two flops before any logic reads them
  always_ff @(posedge sys_clk) begin
    sleep_meta_reg <= sleep_request;
    sleep_sync_reg <= sleep_meta_reg;
    strap_meta_reg <= burst_order_strap;
    strap_sync_reg <= strap_meta_reg;
  end

  // strap is followed for a few cycles after reset, then frozen
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strap_wait_reg <= 2'h0;
      order_reg <= SSDP_INTERLEAVED;
    end else if (strap_wait_reg != `SSDP_STRAP_WAIT) begin
      strap_wait_reg <= 2'(strap_wait_reg + 2'h1);
      order_reg <= ssdp_order_t'(strap_sync_reg);
    end
  end

  // sleep is entered from the pin or from software; low pin means run
  wire logic sleep_want = sleep_sync_reg | force_sleep_reg;
  always_comb begin
    case (state_reg)
      SSDP_RUN: state_next = sleep_want ? SSDP_SLEEP : SSDP_RUN;
      SSDP_SLEEP: state_next = sleep_want ? SSDP_SLEEP : SSDP_RUN;
      default: state_next = SSDP_RUN;
    endcase
  end
  wire logic running = (state_reg == SSDP_RUN) && !sleep_want;

  always_ff @(posedge sys_clk) begin
    if (reset) state_reg <= SSDP_RUN;
    else state_reg <= state_next;
  end

  // access decode: load starts a burst, advance continues one in progress
  wire logic load_cmd = running && !adv_load_n;
  wire logic start_cmd = load_cmd && !chip_select_n;
  wire logic cont_cmd = running && adv_load_n && burst_on_reg;
  wire logic [1:0] cnt_next = 2'(burst_cnt_reg + 2'h1);
  wire logic [1:0] cont_bits;

  ssdp_burst_seq ssdp_burst_seq_i (
    .base_bits(burst_base_reg[1:0]),
    .step(cnt_next),
    .order(order_reg),
    .addr_bits(cont_bits)
  );

  wire logic [ADDR_W-1:0] cont_addr = {burst_base_reg[ADDR_W-1:2], cont_bits};
  wire logic op1_valid_next = start_cmd || cont_cmd;
  wire logic op1_wr_next = start_cmd ? !write_en_n : burst_wr_reg;
  wire logic [ADDR_W-1:0] op1_addr_next = start_cmd ? mem_addr : cont_addr;

  // burst state; sleep or deselect ends any burst
  always_ff @(posedge sys_clk) begin
    if (reset || !running || (load_cmd && chip_select_n)) begin
      burst_on_reg <= 1'b0;
      burst_cnt_reg <= 2'h0;
    end else if (start_cmd) begin
      burst_on_reg <= 1'b1;
      burst_cnt_reg <= 2'h0;
      burst_base_reg <= mem_addr;
      burst_wr_reg <= !write_en_n;
    end else if (cont_cmd) begin
      burst_cnt_reg <= cnt_next;
    end
  end

  // two-stage pipeline: stage one reads, stage two takes write data
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      op1_valid_reg <= 1'b0;
      op2_valid_reg <= 1'b0;
    end else begin
      op1_valid_reg <= op1_valid_next;
      op2_valid_reg <= op1_valid_reg;
    end
    op1_wr_reg <= op1_wr_next;
    op1_addr_reg <= op1_addr_next;
    op1_bw_n_reg <= byte_lane_write_select_n;
    op2_wr_reg <= op1_wr_reg;
    op2_addr_reg <= op1_addr_reg;
    op2_bw_n_reg <= op1_bw_n_reg;
  end

  // output register: only a read stage drives, everything else floats
  always_ff @(posedge sys_clk) begin
    if (reset) drive_reg <= 1'b0;
    else drive_reg <= op1_valid_reg && !op1_wr_reg;
    rdata_reg <= mem[op1_addr_reg];
  end

  // pins are latched on the second rise; each lane keeps its parity bit
  always_ff @(posedge sys_clk) begin
    if (op2_valid_reg && op2_wr_reg) begin
      for (int i = 0; i < LANES; i++) begin
        if (!op2_bw_n_reg[i]) begin
          mem[op2_addr_reg][9*i +: 9] <= {parity_lines_in[i], data_in[8*i +: 8]};
        end
      end
    end
  end

  // unpack stored words: each lane is eight data bits and one parity bit
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      data_out[8*i +: 8] = rdata_reg[9*i +: 8];
      parity_lines_out[i] = rdata_reg[9*i + 8];
    end
  end
  // output enable gates the drivers without a clock, so no edge delays it
  assign data_oe = drive_reg && !output_en_n;
  assign parity_lines_oe = data_oe;

  // register bus: one wait state per access, unmapped reads give zero
  wire logic bus_req = avs_read || avs_write;
  wire logic sel_ctrl = (avs_address == `SSDP_CTRL_OFS);
  wire logic sel_stat = (avs_address == `SSDP_STAT_OFS);
  wire logic [31:0] stat_word = {26'h0, burst_on_reg, drive_reg, burst_cnt_reg,
                                 order_reg == SSDP_INTERLEAVED, state_reg == SSDP_SLEEP};
  wire logic [31:0] read_mux = sel_ctrl ? {31'h0, force_sleep_reg} :
                               sel_stat ? stat_word : 32'h0000_0000;
  assign avs_waitrequest = bus_req && !bus_ack_reg;
  assign avs_readdata = readdata_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_ack_reg <= 1'b0;
      force_sleep_reg <= 1'(`SSDP_CTRL_RESET);
      readdata_reg <= 32'h0000_0000;
    end else begin
      bus_ack_reg <= bus_req && !bus_ack_reg;
      if (bus_req && !bus_ack_reg && avs_read) readdata_reg <= read_mux;
      // a write lands only at the edge where waitrequest is seen low
      if (avs_write && bus_ack_reg && sel_ctrl)
        force_sleep_reg <= avs_writedata[`SSDP_CTRL_FORCE_SLEEP];
    end
  end

  // checks beside the logic
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_sleep_blocks_ops: assert property (!running |=> !op1_valid_reg)
    else $error("access started while asleep");
  a_sleep_release: assert property ($fell(sleep_sync_reg) && !force_sleep_reg
    |=> state_reg == SSDP_RUN) else $error("sleep not left after pin fell");
  a_read_drive: assert property (start_cmd && write_en_n |=> ##1 drive_reg)
    else $error("read data not driven next rise");
  a_read_value: assert property (op1_valid_reg && !op1_wr_reg
    && !(op2_valid_reg && op2_wr_reg) |=> rdata_reg == $past(mem[op1_addr_reg]))
    else $error("read data from wrong word");
  // only the write's own data cycle must float; a read issued right after may drive next
  a_write_float: assert property (start_cmd && !write_en_n
    |=> ##1 !data_oe && !parity_lines_oe) else $error("drivers on during write data");
  a_oe_gates: assert property (output_en_n |-> !data_oe && !parity_lines_oe)
    else $error("drive while output enable high");
  a_write_lane0: assert property (op2_valid_reg && op2_wr_reg && !op2_bw_n_reg[0]
    |=> mem[$past(op2_addr_reg)][8:0] == $past({parity_lines_in[0], data_in[7:0]}))
    else $error("lane zero write lost");
  a_parity_mask: assert property (op2_valid_reg && op2_wr_reg && op2_bw_n_reg[0]
    |=> mem[$past(op2_addr_reg)][8] == $past(mem[op2_addr_reg][8]))
    else $error("masked parity bit changed");
  a_burst_wrap: assert property (cont_cmd && order_reg == SSDP_LINEAR
    |-> op1_addr_next[1:0] == 2'(burst_base_reg[1:0] + burst_cnt_reg + 2'h1))
    else $error("linear burst step wrong");
  a_strap_hold: assert property (strap_wait_reg == `SSDP_STRAP_WAIT
    |=> $stable(order_reg)) else $error("burst order moved after settle");

  c_read: cover property (start_cmd && write_en_n ##2 data_oe);
  c_write_burst: cover property (start_cmd && !write_en_n ##1 cont_cmd [*3]);
  c_sleep: cover property (state_reg == SSDP_RUN ##1 state_reg == SSDP_SLEEP ##[1:20]
    state_reg == SSDP_RUN);
endmodule // ssdp_data_port
`default_nettype wire

// file: sim/ssdp_ctrl_model.sv
// Purpose: memory controller model on the far side of the SRAM data port
// Assumes: one rising-edge clock shared with the port
// Notes: released data pins show the inverse of the last value, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module ssdp_ctrl_model (
  input wire logic sys_clk, // shared clock
  output logic [16:0] mem_addr, // word address
  output logic chip_select_n, // active low
  output logic write_en_n, // active low
  output logic adv_load_n, // low loads, high advances
  output logic [3:0] byte_lane_write_select_n, // per lane, active low
  output logic [31:0] data_in, // data pins toward the port
  output logic [3:0] parity_lines_in // parity pins toward the port
);
  // idle: deselected and released
  initial begin
    {mem_addr, chip_select_n, write_en_n, adv_load_n} = {17'h0, 3'h7};
    {byte_lane_write_select_n, parity_lines_in, data_in} = {4'hF, 36'h0};
  end

  // one burst of n beats, then a deselect so the port floats again
  task automatic burst(input logic wr, input logic [16:0] a, input logic [3:0] bw_n,
                       input int n, input logic [35:0] wd);
    for (int i = 0; i <= n + 1; i++) begin
      @(posedge sys_clk);
      if (i == 0) begin
        {adv_load_n, chip_select_n, write_en_n, mem_addr} <= {2'b00, !wr, a};
        byte_lane_write_select_n <= bw_n;
      end else if (i < n) begin
        adv_load_n <= 1'b1;
      end else begin
        {adv_load_n, chip_select_n} <= 2'b01;
      end
      // beat k must sit on the pins at the second rise after it starts
      if (wr && i >= 2) {parity_lines_in, data_in} <= wd + 36'(i - 2);
      else {parity_lines_in, data_in} <= ~{parity_lines_in, data_in};
    end
    @(posedge sys_clk);
    {parity_lines_in, data_in} <= ~{parity_lines_in, data_in};
  endtask
endmodule // ssdp_ctrl_model
`default_nettype wire

// file: sim/tb_sync_sram_data_port_sleep_mode.sv
// Purpose: self-checking bench for the SRAM data port
// Assumes: controller model drives the memory pins, bench drives the register bus
// Notes: bench holds sleep low as the pad pull-down would, strap high when floating
`timescale 1ns/1ps
`default_nettype none
`include "ssdp_params.svh"
module tb_sync_sram_data_port_sleep_mode;
  logic sys_clk, reset, output_en_n, sleep_request, burst_order_strap, avs_read, avs_write;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, data_in, data_out, rd;
  logic [16:0] mem_addr;
  logic chip_select_n, write_en_n, adv_load_n, data_oe, parity_lines_oe, avs_waitrequest;
  logic [3:0] byte_lane_write_select_n, parity_lines_in, parity_lines_out;
  logic [35:0] mdl [0:3]; // expected contents of the words used
  int n_errors = 0;
  int samples_checked = 0;

  ssdp_data_port ssdp_data_port_i (.sys_clk, .reset, .mem_addr, .chip_select_n, .write_en_n,
    .adv_load_n, .byte_lane_write_select_n, .output_en_n, .sleep_request, .burst_order_strap,
    .data_in, .data_out, .data_oe, .parity_lines_in, .parity_lines_out, .parity_lines_oe,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  ssdp_ctrl_model ssdp_ctrl_model_i (.sys_clk, .mem_addr, .chip_select_n, .write_en_n,
    .adv_load_n, .byte_lane_write_select_n, .data_in, .parity_lines_in);

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one register access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    // no cycle count assumed: only the watchdog ends a wait that never ends
    {avs_write, avs_read, avs_address, avs_writedata} <= {wr, !wr, a, wd};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
    @(posedge sys_clk);
  endtask

  // burst on the memory pins; awake means the port should take it
  task automatic xfer(input logic wr, input logic [1:0] base, input logic [3:0] bw_n,
                      input int n, input logic [35:0] wd, input logic awake);
    logic [1:0] lo;
    logic [35:0] w;
    fork
      ssdp_ctrl_model_i.burst(wr, {15'h0, base}, bw_n, n, wd);
      begin
        repeat (2) @(posedge sys_clk);
        #1 chk({parity_lines_oe, data_oe}, 2'b00);
        for (int k = 0; k < n; k++) begin
          @(posedge sys_clk);
          #1;
          lo = burst_order_strap ? base ^ 2'(k) : base + 2'(k);
          w = wd + 36'(k);
          chk({parity_lines_oe, data_oe}, {2{!wr && awake && !output_en_n}});
          if (!wr && awake && !output_en_n)
            chk({parity_lines_out, data_out}, mdl[lo]);
          for (int l = 0; l < 4; l++) begin
            if (wr && awake && !bw_n[l]) begin
              mdl[lo][8*l +: 8] = w[8*l +: 8];
              mdl[lo][32+l] = w[32+l];
            end
          end
        end
      end
    join
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog, far beyond the couple of hundred cycles the tests need
  initial begin
    #500000;
    n_errors++;
    end_of_test();
  end

  initial begin
    {reset, output_en_n, sleep_request, burst_order_strap} = 4'b1001;
    {avs_address, avs_read, avs_write, avs_writedata} = 38'h0;
    for (int ord = 1; ord >= 0; ord--) begin
      // strap may change only under reset
      reset <= 1'b1;
      burst_order_strap <= ord[0];
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (3) @(posedge sys_clk);
      bus(1'b0, `SSDP_CTRL_OFS, 32'h0, rd);
      chk(rd, `SSDP_CTRL_RESET);
      bus(1'b0, `SSDP_STAT_OFS, 32'h0, rd);
      chk(rd & 32'hFFFF_FFF3, 32'(ord) << 1);
      xfer(1'b1, 2'h0, 4'h0, 4, 36'h5_A5C3_3C00, 1'b1);
      // lanes 0 and 2 masked over a written word: their data and parity must stay
      xfer(1'b1, 2'h2, 4'h5, 1, 36'hF_FFFF_FFFF, 1'b1);
      xfer(1'b0, 2'h1, 4'hF, 4, 36'h0, 1'b1);
      output_en_n <= 1'b1;
      xfer(1'b0, 2'h2, 4'hF, 2, 36'h0, 1'b1);
      output_en_n <= 1'b0;
      // forced sleep refuses both kinds of access and keeps contents
      bus(1'b1, `SSDP_CTRL_OFS, 32'h1, rd);
      bus(1'b0, `SSDP_STAT_OFS, 32'h0, rd);
      chk(rd[0], 1'b1);
      xfer(1'b1, 2'h0, 4'h0, 1, 36'h0, 1'b0);
      xfer(1'b0, 2'h0, 4'hF, 1, 36'h0, 1'b0);
      bus(1'b1, `SSDP_CTRL_OFS, 32'h0, rd);
      repeat (3) @(posedge sys_clk);
      xfer(1'b0, 2'h0, 4'hF, 4, 36'h0, 1'b1);
      // sleep pin, then back to pull-down level before any access
      sleep_request <= 1'b1;
      repeat (4) @(posedge sys_clk);
      bus(1'b0, `SSDP_STAT_OFS, 32'h0, rd);
      chk(rd[0], 1'b1);
      sleep_request <= 1'b0;
      repeat (4) @(posedge sys_clk);
      bus(1'b0, `SSDP_STAT_OFS, 32'h0, rd);
      chk(rd[0], 1'b0);
      // unmapped place: write ignored, read gives zero, device stays awake
      bus(1'b1, 4'h8, 32'hFFFF_FFFF, rd);
      bus(1'b0, 4'h8, 32'h0, rd);
      chk(rd, 32'h0);
      bus(1'b0, `SSDP_CTRL_OFS, 32'h0, rd);
      chk(rd, 32'h0);
    end
    end_of_test();
  end
endmodule // tb_sync_sram_data_port_sleep_mode
`default_nettype wire
